// ### core/mcs_map.vh
// Address map, reset values and codes of the metering config/status bank.
// Assumes 16-bit register addresses and 16-bit data on the register port.
`ifndef MCS_MAP_VH
`define MCS_MAP_VH

// 8-bit configuration and status registers
`define MCS_A_MEAS_MODE      16'he700
`define MCS_A_ACCUM_MODE     16'he701
`define MCS_A_LCYC_BEHAV     16'he702
`define MCS_A_PEAK_HCYC      16'he703
`define MCS_A_SAG_HCYC       16'he704
`define MCS_A_PULSE_LATCH    16'he705
`define MCS_A_FDP_CFG        16'he706
`define MCS_A_DIE_REV        16'he707
`define MCS_A_FE_CFG         16'he708
`define MCS_A_TEMP_A         16'he709
`define MCS_A_TEMP_B         16'he70a
`define MCS_A_TEMP_C         16'he70b
`define MCS_A_TEMP_N         16'he70c
`define MCS_A_KEY_A          16'he7e3
`define MCS_A_LAST_BYTE      16'he7fd
`define MCS_A_KEY_B          16'he7fe

// 16-bit registers
`define MCS_A_PF_A           16'he902
`define MCS_A_PF_B           16'he903
`define MCS_A_PF_C           16'he904
`define MCS_A_PER_A          16'he905
`define MCS_A_PER_B          16'he906
`define MCS_A_PER_C          16'he907
`define MCS_A_ACT_IDLE       16'he908
`define MCS_A_REACT_IDLE     16'he909
`define MCS_A_APP_IDLE       16'he90a

// Reset values
`define MCS_R_MEAS_MODE      16'h001c
`define MCS_R_ACCUM_MODE     16'h0000
`define MCS_R_LCYC_BEHAV     16'h0078
`define MCS_R_PEAK_HCYC      16'h0000
`define MCS_R_SAG_HCYC       16'h0000
`define MCS_R_PULSE_LATCH    16'h0001
`define MCS_R_FDP_CFG        16'h0000
`define MCS_R_FE_CFG         16'h000f
`define MCS_R_KEY            16'h0000
`define MCS_R_IDLE           16'h0000
`define MCS_R_TEMP           8'h00

// Key pair that switches DSP RAM write protection on
`define MCS_KEY_A_LOCK       8'had
`define MCS_KEY_B_LOCK       8'h80

`endif

// ### core/mcs_reg_cell.v
// One read/write register at a fixed address with a fixed reset value.
// Assumes the write strobe and address are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module mcs_reg_cell
#(
  parameter integer    WIDTH = 8,
  parameter [15:0]     ADDR  = 16'h0000,
  parameter [15:0]     RST   = 16'h0000
)
(
  // Clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // Write port
  input  wire              wr_en,
  input  wire [15:0]       addr,
  input  wire [15:0]       wdata,
  // Stored value
  output reg  [WIDTH-1:0]  q
);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= RST[WIDTH-1:0];
    end
    else if (wr_en && (addr == ADDR))
    begin
      q <= wdata[WIDTH-1:0];
    end
  end

endmodule // mcs_reg_cell

`default_nettype wire

// ### core/mcs_cycle_div.v
// Event divider: one strobe after every `period` input ticks.
// Assumes tick is a one-cycle pulse; period of zero stops the strobe.
`timescale 1ns/1ps
`default_nettype none

module mcs_cycle_div
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Events and programmed count
  input  wire        tick,
  input  wire [7:0]  period,
  // One-cycle strobe
  output reg         strobe_q
);

  reg  [7:0] count_q;
  wire [8:0] count_inc;

  assign count_inc = {1'b0, count_q} + 9'h001;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q  <= 8'h00;
      strobe_q <= 1'b0;
    end
    else
    begin
      strobe_q <= 1'b0;
      if (period == 8'h00)
      begin
        count_q <= 8'h00;
      end
      else if (tick)
      begin
        // >= so a count lowered mid-run still ends the window
        if (count_inc >= {1'b0, period})
        begin
          count_q  <= 8'h00;
          strobe_q <= 1'b1;
        end
        else
        begin
          count_q <= count_inc[7:0];
        end
      end
    end
  end

endmodule // mcs_cycle_div

`default_nettype wire

// ### core/mcs_regs.v
// Metering configuration and status register bank.
// Assumes the serial port engine presents one-cycle read and write
// strobes with a 16-bit address and data, synchronous to SYS_CLK.
//
// Overview of operation
// - Two key registers toggle DSP RAM protection
// - Capture data of last good byte access
// - Latch energy every N energy pulses
// - Peak interval in half cycles, reset zero
// - Sag interval in half cycles, reset zero
// - Per-phase 16-bit read-only line period
// - Per-phase 16-bit read-only power factor
// - Three 16-bit idle thresholds, reset zero
// - Four signed temperature offsets, reset zero
// - Measurement mode register resets to 0x1c
// - Line-cycle behaviour register resets to 0x78
// - Front-end config register resets to 0x0f
`include "mcs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module mcs_regs
#(
  // Arbitrary value, not a real revision code
  parameter [7:0] DIE_REVISION = 8'h01
)
(
  // Clock and reset
  input  wire        SYS_CLK,
  input  wire        RESETN,

  // Register port from the serial engine
  input  wire [15:0] REG_ADDR,
  input  wire [15:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [15:0] REG_RDATA,
  output reg         REG_RVALID,

  // Event inputs from the datapath
  input  wire        ENERGY_PULSE,
  input  wire        HALF_CYCLE,

  // Measured values from the datapath
  input  wire [7:0]  PHASE_A_TEMP_OFFSET,
  input  wire [7:0]  PHASE_B_TEMP_OFFSET,
  input  wire [7:0]  PHASE_C_TEMP_OFFSET,
  input  wire [7:0]  NEUTRAL_TEMP_OFFSET,
  input  wire [15:0] PHASE_A_POWER_FACTOR,
  input  wire [15:0] PHASE_B_POWER_FACTOR,
  input  wire [15:0] PHASE_C_POWER_FACTOR,
  input  wire [15:0] PHASE_A_LINE_PERIOD,
  input  wire [15:0] PHASE_B_LINE_PERIOD,
  input  wire [15:0] PHASE_C_LINE_PERIOD,

  // Configuration to the datapath
  output wire [7:0]  MEASUREMENT_MODE_CFG,
  output wire [7:0]  ACCUMULATION_MODE_CFG,
  output wire [7:0]  LINE_CYCLE_ACCUM_BEHAVIOUR,
  output wire [7:0]  PEAK_HALF_CYCLE_COUNT,
  output wire [7:0]  SAG_HALF_CYCLE_COUNT,
  output wire [7:0]  PULSES_PER_ENERGY_LATCH,
  output wire [7:0]  FAST_DATA_PORT_CFG,
  output wire [7:0]  FRONTEND_CONVERTER_CFG,
  output wire [15:0] ACTIVE_IDLE_THRESHOLD,
  output wire [15:0] REACTIVE_IDLE_THRESHOLD,
  output wire [15:0] APPARENT_IDLE_THRESHOLD,

  // Derived controls
  output reg         DSP_RAM_WP,
  output wire        ENERGY_LATCH,
  output wire        PEAK_WINDOW_END,
  output wire        SAG_WINDOW_END
);

  wire [7:0]  key_a;
  wire [7:0]  key_b;
  reg  [7:0]  temp_a_q;
  reg  [7:0]  temp_b_q;
  reg  [7:0]  temp_c_q;
  reg  [7:0]  temp_n_q;
  reg  [15:0] pf_a_q;
  reg  [15:0] pf_b_q;
  reg  [15:0] pf_c_q;
  reg  [15:0] per_a_q;
  reg  [15:0] per_b_q;
  reg  [15:0] per_c_q;
  reg  [7:0]  last_byte_q;
  reg  [15:0] rd_d;
  reg         is_byte_d;
  reg         is_rw_byte_d;

  // Read/write configuration registers

  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_MEAS_MODE), .RST(`MCS_R_MEAS_MODE))
  u_meas_mode
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (MEASUREMENT_MODE_CFG)
  );

  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_ACCUM_MODE), .RST(`MCS_R_ACCUM_MODE))
  u_accum_mode
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (ACCUMULATION_MODE_CFG)
  );

  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_LCYC_BEHAV), .RST(`MCS_R_LCYC_BEHAV))
  u_lcyc_behav
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (LINE_CYCLE_ACCUM_BEHAVIOUR)
  );

  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_PEAK_HCYC), .RST(`MCS_R_PEAK_HCYC))
  u_peak_hcyc
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (PEAK_HALF_CYCLE_COUNT)
  );

  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_SAG_HCYC), .RST(`MCS_R_SAG_HCYC))
  u_sag_hcyc
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (SAG_HALF_CYCLE_COUNT)
  );

  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_PULSE_LATCH), .RST(`MCS_R_PULSE_LATCH))
  u_pulse_latch
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (PULSES_PER_ENERGY_LATCH)
  );

  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_FDP_CFG), .RST(`MCS_R_FDP_CFG))
  u_fdp_cfg
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (FAST_DATA_PORT_CFG)
  );

  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_FE_CFG), .RST(`MCS_R_FE_CFG))
  u_fe_cfg
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (FRONTEND_CONVERTER_CFG)
  );

  // Protection keys
  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_KEY_A), .RST(`MCS_R_KEY))
  u_key_a
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (key_a)
  );

  mcs_reg_cell #(.WIDTH(8), .ADDR(`MCS_A_KEY_B), .RST(`MCS_R_KEY))
  u_key_b
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (key_b)
  );

  // Idle thresholds
  mcs_reg_cell #(.WIDTH(16), .ADDR(`MCS_A_ACT_IDLE), .RST(`MCS_R_IDLE))
  u_act_idle
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (ACTIVE_IDLE_THRESHOLD)
  );

  mcs_reg_cell #(.WIDTH(16), .ADDR(`MCS_A_REACT_IDLE), .RST(`MCS_R_IDLE))
  u_react_idle
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (REACTIVE_IDLE_THRESHOLD)
  );

  mcs_reg_cell #(.WIDTH(16), .ADDR(`MCS_A_APP_IDLE), .RST(`MCS_R_IDLE))
  u_app_idle
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .q     (APPARENT_IDLE_THRESHOLD)
  );

  // Event dividers
  mcs_cycle_div u_energy_div
  (
    .clk      (SYS_CLK),
    .rst_n    (RESETN),
    .tick     (ENERGY_PULSE),
    .period   (PULSES_PER_ENERGY_LATCH),
    .strobe_q (ENERGY_LATCH)
  );

  mcs_cycle_div u_peak_div
  (
    .clk      (SYS_CLK),
    .rst_n    (RESETN),
    .tick     (HALF_CYCLE),
    .period   (PEAK_HALF_CYCLE_COUNT),
    .strobe_q (PEAK_WINDOW_END)
  );

  mcs_cycle_div u_sag_div
  (
    .clk      (SYS_CLK),
    .rst_n    (RESETN),
    .tick     (HALF_CYCLE),
    .period   (SAG_HALF_CYCLE_COUNT),
    .strobe_q (SAG_WINDOW_END)
  );

  // Measured values sampled each cycle so a read sees one stable word
  always @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      temp_a_q <= `MCS_R_TEMP;
      temp_b_q <= `MCS_R_TEMP;
      temp_c_q <= `MCS_R_TEMP;
      temp_n_q <= `MCS_R_TEMP;
      pf_a_q   <= 16'h0000;
      pf_b_q   <= 16'h0000;
      pf_c_q   <= 16'h0000;
      per_a_q  <= 16'h0000;
      per_b_q  <= 16'h0000;
      per_c_q  <= 16'h0000;
    end
    else
    begin
      temp_a_q <= PHASE_A_TEMP_OFFSET;
      temp_b_q <= PHASE_B_TEMP_OFFSET;
      temp_c_q <= PHASE_C_TEMP_OFFSET;
      temp_n_q <= NEUTRAL_TEMP_OFFSET;
      pf_a_q   <= PHASE_A_POWER_FACTOR;
      pf_b_q   <= PHASE_B_POWER_FACTOR;
      pf_c_q   <= PHASE_C_POWER_FACTOR;
      per_a_q  <= PHASE_A_LINE_PERIOD;
      per_b_q  <= PHASE_B_LINE_PERIOD;
      per_c_q  <= PHASE_C_LINE_PERIOD;
    end
  end

  // Read decode; read-only entries have no write path at all
  always @*
  begin
    rd_d         = 16'h0000;
    is_byte_d    = 1'b1;
    is_rw_byte_d = 1'b1;
    if (REG_ADDR == `MCS_A_MEAS_MODE)
      rd_d = {8'h00, MEASUREMENT_MODE_CFG};
    else if (REG_ADDR == `MCS_A_ACCUM_MODE)
      rd_d = {8'h00, ACCUMULATION_MODE_CFG};
    else if (REG_ADDR == `MCS_A_LCYC_BEHAV)
      rd_d = {8'h00, LINE_CYCLE_ACCUM_BEHAVIOUR};
    else if (REG_ADDR == `MCS_A_PEAK_HCYC)
      rd_d = {8'h00, PEAK_HALF_CYCLE_COUNT};
    else if (REG_ADDR == `MCS_A_SAG_HCYC)
      rd_d = {8'h00, SAG_HALF_CYCLE_COUNT};
    else if (REG_ADDR == `MCS_A_PULSE_LATCH)
      rd_d = {8'h00, PULSES_PER_ENERGY_LATCH};
    else if (REG_ADDR == `MCS_A_FDP_CFG)
      rd_d = {8'h00, FAST_DATA_PORT_CFG};
    else if (REG_ADDR == `MCS_A_FE_CFG)
      rd_d = {8'h00, FRONTEND_CONVERTER_CFG};
    else if (REG_ADDR == `MCS_A_KEY_A)
      rd_d = {8'h00, key_a};
    else if (REG_ADDR == `MCS_A_KEY_B)
      rd_d = {8'h00, key_b};
    else
    begin
      is_rw_byte_d = 1'b0;
      if (REG_ADDR == `MCS_A_DIE_REV)
        rd_d = {8'h00, DIE_REVISION};
      else if (REG_ADDR == `MCS_A_TEMP_A)
        rd_d = {8'h00, temp_a_q};
      else if (REG_ADDR == `MCS_A_TEMP_B)
        rd_d = {8'h00, temp_b_q};
      else if (REG_ADDR == `MCS_A_TEMP_C)
        rd_d = {8'h00, temp_c_q};
      else if (REG_ADDR == `MCS_A_TEMP_N)
        rd_d = {8'h00, temp_n_q};
      else if (REG_ADDR == `MCS_A_LAST_BYTE)
        rd_d = {8'h00, last_byte_q};
      else
      begin
        is_byte_d = 1'b0;
        if (REG_ADDR == `MCS_A_PF_A)
          rd_d = pf_a_q;
        else if (REG_ADDR == `MCS_A_PF_B)
          rd_d = pf_b_q;
        else if (REG_ADDR == `MCS_A_PF_C)
          rd_d = pf_c_q;
        else if (REG_ADDR == `MCS_A_PER_A)
          rd_d = per_a_q;
        else if (REG_ADDR == `MCS_A_PER_B)
          rd_d = per_b_q;
        else if (REG_ADDR == `MCS_A_PER_C)
          rd_d = per_c_q;
        else if (REG_ADDR == `MCS_A_ACT_IDLE)
          rd_d = ACTIVE_IDLE_THRESHOLD;
        else if (REG_ADDR == `MCS_A_REACT_IDLE)
          rd_d = REACTIVE_IDLE_THRESHOLD;
        else if (REG_ADDR == `MCS_A_APP_IDLE)
          rd_d = APPARENT_IDLE_THRESHOLD;
        else
          rd_d = 16'h0000; // Unmapped: reads zero, writes dropped
      end
    end
  end

  // Read answer, last byte access and protection state
  always @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      REG_RDATA   <= 16'h0000;
      REG_RVALID  <= 1'b0;
      last_byte_q <= 8'h00;
      DSP_RAM_WP  <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
      begin
        REG_RDATA <= rd_d;
      end
      // A read wins over a write in the same cycle
      if (REG_RD && is_byte_d)
      begin
        last_byte_q <= rd_d[7:0];
      end
      else if (REG_WR && is_rw_byte_d)
      begin
        last_byte_q <= REG_WDATA[7:0];
      end
      // Both keys must hold the lock pair; any other pair unlocks
      DSP_RAM_WP <= (key_a == `MCS_KEY_A_LOCK) &&
                    (key_b == `MCS_KEY_B_LOCK);
    end
  end

endmodule // mcs_regs

`default_nettype wire

// ### testbench/mcs_regs_checker.sv
// Port checker for the metering config/status register bank.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module mcs_regs_checker
(
  // Clock and reset
  input wire        SYS_CLK,
  input wire        RESETN,
  // Register port
  input wire [15:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire        REG_WR,
  input wire        REG_RD,
  input wire [15:0] REG_RDATA,
  input wire        REG_RVALID,
  // Events, measured values and configuration
  input wire        ENERGY_PULSE,
  input wire        ENERGY_LATCH,
  input wire [15:0] PHASE_A_POWER_FACTOR,
  input wire [7:0]  MEASUREMENT_MODE_CFG,
  input wire [7:0]  PULSES_PER_ENERGY_LATCH,
  input wire [7:0]  PEAK_HALF_CYCLE_COUNT,
  input wire [15:0] ACTIVE_IDLE_THRESHOLD
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_rd(a);
    REG_RD && REG_ADDR == a;
  endsequence
  sequence s_wr(a);
    REG_WR && REG_ADDR == a;
  endsequence

  rd_answer_a:
    assert property (REG_RD |=> REG_RVALID) else $error("Read got no valid");
  valid_cause_a:
    assert property (REG_RVALID |-> $past(REG_RD)) else $error("Valid without read");
  pf_read_a:
    assert property (s_rd(16'he902) |=> REG_RDATA == $past(PHASE_A_POWER_FACTOR, 2))
      else $error("Power factor read wrong");
  mode_write_a:
    assert property (s_wr(16'he700) |=> MEASUREMENT_MODE_CFG == $past(REG_WDATA[7:0]))
      else $error("Mode write lost");
  mode_hold_a:
    assert property (!(REG_WR && REG_ADDR == 16'he700) |=> $stable(MEASUREMENT_MODE_CFG))
      else $error("Mode changed");
  peak_write_a:
    assert property (s_wr(16'he703) |=> PEAK_HALF_CYCLE_COUNT == $past(REG_WDATA[7:0]))
      else $error("Peak count write lost");
  idle_write_a:
    assert property (s_wr(16'he908) |=> ACTIVE_IDLE_THRESHOLD == $past(REG_WDATA))
      else $error("Idle threshold write lost");
  latch_one_a:
    assert property (ENERGY_PULSE && PULSES_PER_ENERGY_LATCH == 8'h01 |=> ENERGY_LATCH)
      else $error("Latch missed");
  latch_cause_a:
    assert property (ENERGY_LATCH |-> $past(ENERGY_PULSE)) else $error("Latch without pulse");
endmodule // mcs_regs_checker

bind mcs_regs mcs_regs_checker chk_u (.SYS_CLK, .RESETN, .REG_ADDR, .REG_WDATA, .REG_WR,
  .REG_RD, .REG_RDATA, .REG_RVALID, .ENERGY_PULSE, .ENERGY_LATCH, .PHASE_A_POWER_FACTOR,
  .MEASUREMENT_MODE_CFG, .PULSES_PER_ENERGY_LATCH, .PEAK_HALF_CYCLE_COUNT,
  .ACTIVE_IDLE_THRESHOLD);

`default_nettype wire

// ### testbench/mcs_host_model.sv
// Host model: one register access at a time on the bank's port.
// Assumes requests are taken on a rising edge, RVALID one edge later.
`timescale 1ns/1ps
`default_nettype none

module mcs_host_model
(
  // Clock
  input  wire         clk,
  // Register port
  output logic [15:0] addr,
  output logic [15:0] wdata,
  output logic        wr,
  output logic        rd,
  input  wire  [15:0] rdata,
  input  wire         rvalid
);
  initial
  begin
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic wr_reg(input [15:0] a, input [15:0] d);
    // Reserved holes are never written
    if ((a >= 16'he70d && a <= 16'he7e2) || (a >= 16'he7e4 && a <= 16'he7fc))
      return;
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    // Released lines must not keep the last value
    addr = ~a;
    wdata = ~d;
  endtask

  task automatic rd_reg(input [15:0] a, output [15:0] d, output ok);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    addr = ~a;
    ok = rvalid;
    d = rdata;
  endtask
endmodule // mcs_host_model

`default_nettype wire

// ### testbench/mcs_regs_tb.sv
// Self-checking bench for the metering config/status register bank.
// Assumes the host model and the bound port checker are compiled too.
`timescale 1ns/1ps
`default_nettype none

module mcs_regs_tb;
  logic        sys_clk, resetn, ep, hc;
  logic [7:0]  tmp [4];
  logic [15:0] pf [3];
  logic [15:0] per [3];
  wire  [15:0] reg_addr, reg_wdata, reg_rdata;
  wire         reg_wr, reg_rd, reg_rvalid;
  wire  [7:0]  mm;
  wire         wp, el, pe, se;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [15:0] d;
  logic        ok;

  mcs_host_model host_u (.clk(sys_clk), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr),
    .rd(reg_rd), .rdata(reg_rdata), .rvalid(reg_rvalid));

  mcs_regs dut_u (.SYS_CLK(sys_clk), .RESETN(resetn), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .ENERGY_PULSE(ep), .HALF_CYCLE(hc),
    .PHASE_A_TEMP_OFFSET(tmp[0]), .PHASE_B_TEMP_OFFSET(tmp[1]),
    .PHASE_C_TEMP_OFFSET(tmp[2]), .NEUTRAL_TEMP_OFFSET(tmp[3]),
    .PHASE_A_POWER_FACTOR(pf[0]), .PHASE_B_POWER_FACTOR(pf[1]),
    .PHASE_C_POWER_FACTOR(pf[2]), .PHASE_A_LINE_PERIOD(per[0]),
    .PHASE_B_LINE_PERIOD(per[1]), .PHASE_C_LINE_PERIOD(per[2]),
    .MEASUREMENT_MODE_CFG(mm), .ACCUMULATION_MODE_CFG(), .LINE_CYCLE_ACCUM_BEHAVIOUR(),
    .PEAK_HALF_CYCLE_COUNT(), .SAG_HALF_CYCLE_COUNT(), .PULSES_PER_ENERGY_LATCH(),
    .FAST_DATA_PORT_CFG(), .FRONTEND_CONVERTER_CFG(), .ACTIVE_IDLE_THRESHOLD(),
    .REACTIVE_IDLE_THRESHOLD(), .APPARENT_IDLE_THRESHOLD(), .DSP_RAM_WP(wp),
    .ENERGY_LATCH(el), .PEAK_WINDOW_END(pe), .SAG_WINDOW_END(se));

  task automatic chk(input [15:0] got, input [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input [15:0] a, input [15:0] exp);
    host_u.rd_reg(a, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(d, exp);
  endtask

  task automatic t_reset_vals;
    logic [15:0] ra [15] = '{16'he7fd, 16'he700, 16'he701, 16'he702, 16'he703, 16'he704,
      16'he705, 16'he706, 16'he708, 16'he7e3, 16'he7fe, 16'he908, 16'he909, 16'he90a,
      16'he707};
    logic [15:0] rv [15] = '{16'h0000, 16'h001c, 16'h0000, 16'h0078, 16'h0000, 16'h0000,
      16'h0001, 16'h0000, 16'h000f, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0001};
    for (int i = 0; i < 15; i++)
      rd_chk(ra[i], rv[i]);
  endtask

  task automatic t_write_back;
    host_u.wr_reg(16'he700, 16'h00a5);
    chk({8'h00, mm}, 16'h00a5);
    rd_chk(16'he700, 16'h00a5);
    // Upper byte must be dropped on byte registers
    host_u.wr_reg(16'he702, 16'hff87);
    rd_chk(16'he702, 16'h0087);
    host_u.wr_reg(16'he708, 16'h00f0);
    rd_chk(16'he708, 16'h00f0);
    host_u.wr_reg(16'he703, 16'h00ff);
    rd_chk(16'he703, 16'h00ff);
    host_u.wr_reg(16'he704, 16'h0080);
    rd_chk(16'he704, 16'h0080);
    for (logic [15:0] a = 16'he908; a <= 16'he90a; a++)
    begin
      host_u.wr_reg(a, a ^ 16'h5a5a);
      rd_chk(a, a ^ 16'h5a5a);
    end
  endtask

  task automatic t_measured;
    pf[0] = 16'h2222;
    for (int i = 0; i < 4; i++)
      rd_chk(16'he709 + 16'(i), {8'h00, tmp[i]});
    for (int i = 0; i < 3; i++)
      rd_chk(16'he902 + 16'(i), pf[i]);
    for (int i = 0; i < 3; i++)
      rd_chk(16'he905 + 16'(i), per[i]);
    host_u.wr_reg(16'he709, 16'h0055);
    host_u.wr_reg(16'he905, 16'hbeef);
    host_u.wr_reg(16'he707, 16'h00ee);
    rd_chk(16'he709, {8'h00, tmp[0]});
    rd_chk(16'he905, per[0]);
    rd_chk(16'he707, 16'h0001);
    rd_chk(16'he7e4, 16'h0000);
  endtask

  task automatic t_last;
    host_u.wr_reg(16'he701, 16'h005a);
    rd_chk(16'he7fd, 16'h005a);
    rd_chk(16'he701, 16'h005a);
    host_u.wr_reg(16'he70b, 16'h0033);
    host_u.wr_reg(16'he909, 16'h1234);
    rd_chk(16'he7fd, 16'h005a);
    rd_chk(16'he70a, {8'h00, tmp[1]});
    rd_chk(16'he7fd, {8'h00, tmp[1]});
  endtask

  task automatic t_keys;
    host_u.wr_reg(16'he7e3, 16'h00ad);
    rd_chk(16'he7e3, 16'h00ad);
    chk({15'h0000, wp}, 16'h0000);
    host_u.wr_reg(16'he7fe, 16'h0080);
    chk({15'h0000, wp}, 16'h0000);
    @(posedge sys_clk);
    #1;
    chk({15'h0000, wp}, 16'h0001);
    host_u.wr_reg(16'he7fe, 16'h0000);
    chk({15'h0000, wp}, 16'h0001);
    @(posedge sys_clk);
    #1;
    chk({15'h0000, wp}, 16'h0000);
  endtask

  task automatic t_dividers;
    host_u.wr_reg(16'he705, 16'h0003);
    host_u.wr_reg(16'he703, 16'h0002);
    host_u.wr_reg(16'he704, 16'h0003);
    for (int i = 1; i <= 4; i++)
    begin
      @(posedge sys_clk);
      #1;
      ep = 1'b1;
      hc = 1'b1;
      @(posedge sys_clk);
      #1;
      ep = 1'b0;
      hc = 1'b0;
      chk({13'h0, el, pe, se}, {13'h0, i == 3, i == 2 || i == 4, i == 3});
    end
    host_u.wr_reg(16'he705, 16'h0001);
    @(posedge sys_clk);
    #1;
    ep = 1'b1;
    @(posedge sys_clk);
    #1;
    ep = 1'b0;
    chk({15'h0000, el}, 16'h0001);
  endtask

  // Mid-run reset with protection on: mode, peak count, key A and protection must fall back
  task automatic t_rereset;
    host_u.wr_reg(16'he7fe, 16'h0080);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({15'h0000, wp}, 16'h0001);
    resetn = 1'b0;
    @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    chk({8'h00, mm}, 16'h001c);
    chk({15'h0000, wp}, 16'h0000);
    rd_chk(16'he703, 16'h0000);
    rd_chk(16'he7e3, 16'h0000);
    rd_chk(16'he700, 16'h001c);
  endtask

  task automatic summarize;
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Whole run needs under two hundred cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      summarize;
    end
  end

  initial
  begin
    resetn = 1'b0;
    ep = 1'b0;
    hc = 1'b0;
    tmp = '{8'h9c, 8'h11, 8'h7f, 8'h80};
    pf = '{16'h7fff, 16'h4000, 16'h0001};
    per = '{16'h1388, 16'h1389, 16'h138a};
    repeat (16) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    t_reset_vals;
    t_write_back;
    t_measured;
    t_last;
    t_keys;
    t_dividers;
    t_rereset;
    summarize;
  end
endmodule // mcs_regs_tb

`default_nettype wire
